// [design/owps_pkg.sv]
// package for the one-wire programming slave: constants and carriers
// assumes a 200 MHz system clock; all times are converted to cycles here
package owps_pkg;
    localparam int          CLK_MHZ          = 200;
    // bit timing in ns
    localparam int          BIT_PERIOD_NS    = 1000;
    localparam int          BIT_THRESH_NS    = 500;
    // must outlast the master's low after its handover fall, or the first bit is cut
    localparam int          SLV_TAKEOVER_NS  = 750;
    localparam int          BIT_ONE_NS       = 750;
    localparam int          BIT_ZERO_NS      = 250;
    localparam int          BUS_TIMEOUT_US   = 20;
    localparam int          ENTRY_WINDOW_US  = 100;
    localparam int          BIT_PERIOD_CYC   = (BIT_PERIOD_NS * CLK_MHZ) / 1000;
    localparam int          BIT_THRESH_CYC   = (BIT_THRESH_NS * CLK_MHZ + 999) / 1000;
    localparam int          SLV_TKO_CYC      = (SLV_TAKEOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int          BIT_ONE_CYC      = (BIT_ONE_NS * CLK_MHZ + 999) / 1000;
    localparam int          BIT_ZERO_CYC     = (BIT_ZERO_NS * CLK_MHZ + 999) / 1000;
    localparam int          RELEASE_CYC      = (BIT_PERIOD_CYC * 3) / 4;
    localparam int          TIMEOUT_CYC      = BUS_TIMEOUT_US * CLK_MHZ;
    localparam int          ENTRY_WIN_CYC    = ENTRY_WINDOW_US * CLK_MHZ;
    localparam int          CNT_W            = 16;
    localparam int          ENTRY_W          = 16;
    // command addresses (7-bit)
    localparam logic [6:0]  ADDR_CTRL        = 7'h58;
    localparam logic [6:0]  ADDR_SIGNATURE   = 7'h5A;
    localparam logic [15:0] SIG_OEM          = 16'h7253;
    localparam logic [15:0] SIG_TIER1        = 16'h8364;
    localparam int          CHK_ERR_BIT      = 8;
    localparam int          SIG_A_BIT        = 2;
    localparam int          SIG_B_BIT        = 1;
    localparam logic [7:0]  CRC_SEED         = 8'hAA;
    localparam logic [8:0]  CRC_POLY         = 9'h107;
    localparam logic [15:0] CRC_LOW_MASK     = 16'hFF00;
    localparam int          CRC_W            = 8;

    typedef struct packed {
        logic [6:0]  addr;
        logic [15:0] data;
    } owps_wr_t;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [15:0] word;
    } owps_crc_in_t;
endpackage

// [design/owps_slave.sv]
// one-wire programming slave: entry by signature, bit decoding, read and write
// assumes line input from a pin (synchronised here) and memory behind wr/rd ports
// Notes on behaviour
// R1 - every byte on the link goes most significant bit first
// R2 - command byte: address in bits 7..1, bit 0 high means read
// R3 - master frames each transaction with start and stop rising edges
// R4 - write is start, write command, two data bytes, stop
// R5 - missing rising edges during a write time out and drop the data
// R6 - read is start then command with select bit set
// R7 - master sends zero handover bit, releases at three quarters
// R8 - after handover falling edge device drives low for takeover time
// R9 - device sends two bytes, zero handover bit, releases at three quarters
// R10 - master drives low for its takeover then issues stop
// R11 - drivers overlap low at takeover so line never floats
// R12 - with no master takeover device times out, waits for new start
// R13 - entry accepted only within window after power-on reset
// R14 - diagnostic mode allows signature entry without power-on reset
// R15 - output enabled during entry, released once command mode active
// R16 - outside command mode link traffic is ignored; a read command still pulses rd_req_o for one cycle
// R17 - master waits programming time between non-volatile writes
// R18 - each area has 8-bit checksum; mismatch sets status bit 8
// R19 - checksum over addresses ascending, words fed msb first
// R20 - stored checksum byte counts as zero during computation
// R21 - polynomial x8+x2+x+1, seed AAh, data xored at x8; the engine shifts each data bit in at bit 0 instead
// R22 - two signatures, differing access rights per region
// R23 - no rising edge for timeout time resets bus to idle; the state machine exempts ST_TKO, ST_SEND and ST_REL
// R24 - bit value is width of high pulse in fixed period
// R25 - command mode persists until next power-on reset
// R26 - high width compared against mid threshold to decode bits
`timescale 1ns/1ps
module owps_slave
    import owps_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    line_i,
    output logic                         line_o,
    output logic                         line_oe_n_o,
    input  wire logic                    diag_mode_i,
    input  wire logic                    area_match_i,
    input  wire logic [15:0]             rd_data_i,
    output logic                         rd_req_o,
    output owps_pkg::owps_wr_t           wr_o,
    output logic                         wr_valid_o,
    output logic                         cmd_mode_o,
    output logic                         sig_tier1_o,
    output logic [15:0]                  ctrl_status_o,
    input  wire owps_pkg::owps_crc_in_t  crc_in_i,
    output logic [7:0]                   crc_o,
    output logic                         crc_done_o
);
    import owps_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CMD    = 3'b001,
        ST_WDATA  = 3'b010,
        ST_HOVER  = 3'b011,
        ST_TKO    = 3'b100,
        ST_SEND   = 3'b101,
        ST_REL    = 3'b110,
        ST_WAIT   = 3'b111
    } owps_state_t;

    owps_state_t        state_r;
    logic [2:0]         sync_r;
    logic               line_r;
    logic               rise;
    logic               fall;
    logic [CNT_W-1:0]   high_cnt_r;
    logic [CNT_W-1:0]   idle_cnt_r;
    logic [CNT_W-1:0]   tx_cnt_r;
    logic [ENTRY_W-1:0] entry_cnt_r;
    logic               entry_open_r;
    logic [4:0]         bit_cnt_r;
    logic               commit_r;
    logic [23:0]        shift_r;
    logic [15:0]        tx_word_r;
    logic               bit_val;
    logic               cmd_mode_r;
    logic               sig_tier1_r;
    logic               sig_oem_r;
    logic               chk_err_r;
    logic [7:0]         crc_r;
    logic [7:0]         crc_nxt;

    // three-stage synchroniser; edges only from agreeing later stages
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            sync_r <= 3'b111;
        else
            sync_r <= {sync_r[1:0], line_i};
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            line_r <= 1'b1;
        else if (sync_r[1] == sync_r[2])
            line_r <= sync_r[2];
    end

    assign rise = (sync_r[1] == sync_r[2]) && sync_r[2] && !line_r;
    assign fall = (sync_r[1] == sync_r[2]) && !sync_r[2] && line_r;
    assign bit_val = (high_cnt_r >= CNT_W'(BIT_THRESH_CYC)); // [R24] [R26]

    // high-pulse width measurement
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || rise)
            high_cnt_r <= '0;
        else if (line_r && high_cnt_r != '1)
            high_cnt_r <= high_cnt_r + 1'b1;
    end

    // time since last rising edge
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || rise)
            idle_cnt_r <= '0;
        else if (idle_cnt_r != '1)
            idle_cnt_r <= idle_cnt_r + 1'b1;
    end

    // entry window after reset; reset here stands for power-on reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            entry_cnt_r  <= '0;
            entry_open_r <= 1'b1;
        end
        else if (entry_cnt_r == ENTRY_W'(ENTRY_WIN_CYC - 1))
            entry_open_r <= 1'b0; // [R13]
        else
            entry_cnt_r <= entry_cnt_r + 1'b1;
    end

    // bus state machine
    always_ff @(posedge clk_i)
    begin
        wr_valid_o <= 1'b0;
        rd_req_o   <= 1'b0;
        commit_r   <= 1'b0;
        if (sys_rst_i)
        begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= '0;
            shift_r   <= '0;
            tx_word_r <= '0;
            tx_cnt_r  <= '0;
            wr_o      <= '0;
        end
        else if (idle_cnt_r >= CNT_W'(TIMEOUT_CYC) && state_r != ST_IDLE
                 && state_r != ST_TKO && state_r != ST_SEND && state_r != ST_REL)
            state_r <= ST_IDLE; // [R5] [R12] [R23]
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    wr_valid_o <= commit_r && cmd_mode_r; // [R5] [R16]
                    if (commit_r)
                        wr_o <= {shift_r[23:17], shift_r[15:0]};
                    if (rise)
                    begin
                        state_r   <= ST_CMD; // [R3]
                        bit_cnt_r <= '0;
                    end
                end
                ST_CMD, ST_WDATA:
                    // a bit ends on the rise of the next one; stop rise ends frame
                    if (rise && high_cnt_r != '0)
                    begin
                        shift_r   <= {shift_r[22:0], bit_val}; // [R1]
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        if (state_r == ST_CMD && bit_cnt_r == 5'd7)
                        begin
                            bit_cnt_r <= '0;
                            if (bit_val) // [R2] [R6]
                                state_r <= ST_HOVER;
                            else
                                state_r <= ST_WDATA; // [R4]
                        end
                        else if (state_r == ST_WDATA && bit_cnt_r == 5'd15)
                        begin
                            state_r   <= ST_IDLE; // [R4] this rise is the stop
                            bit_cnt_r <= '0;
                            commit_r  <= 1'b1;
                        end
                    end
                ST_HOVER:
                    if (fall)
                    begin
                        state_r  <= ST_TKO; // [R7] [R8]
                        tx_cnt_r <= '0;
                        rd_req_o <= 1'b1;
                    end
                ST_TKO:
                    if (tx_cnt_r == CNT_W'(SLV_TKO_CYC - 1))
                    begin
                        state_r   <= ST_SEND;
                        tx_cnt_r  <= '0;
                        bit_cnt_r <= '0;
                        tx_word_r <= rd_data_i;
                    end
                    else
                        tx_cnt_r <= tx_cnt_r + 1'b1;
                ST_SEND:
                    if (tx_cnt_r == CNT_W'(BIT_PERIOD_CYC - 1))
                    begin
                        tx_cnt_r  <= '0;
                        tx_word_r <= {tx_word_r[14:0], 1'b0}; // [R1] [R9]
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        if (bit_cnt_r == 5'd15)
                            state_r <= ST_REL;
                    end
                    else
                        tx_cnt_r <= tx_cnt_r + 1'b1;
                ST_REL:
                    if (tx_cnt_r == CNT_W'(RELEASE_CYC - 1))
                    begin
                        state_r  <= ST_WAIT; // [R9] [R10]
                        tx_cnt_r <= '0;
                    end
                    else
                        tx_cnt_r <= tx_cnt_r + 1'b1;
                ST_WAIT:
                    if (rise)
                    begin
                        state_r   <= ST_IDLE; // stop after a read, never commits
                        bit_cnt_r <= '0;
                    end
            endcase
        end
    end

    // command mode entry; sticks until reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cmd_mode_r  <= 1'b0;
            sig_tier1_r <= 1'b0;
            sig_oem_r   <= 1'b0;
        end
        else if (!cmd_mode_r && commit_r
                 && shift_r[23:16] == {ADDR_SIGNATURE, 1'b0}
                 && (entry_open_r || diag_mode_i)) // [R13] [R14]
        begin
            if (shift_r[15:0] == SIG_TIER1)
            begin
                cmd_mode_r  <= 1'b1; // [R22] [R25]
                sig_tier1_r <= 1'b1;
            end
            else if (shift_r[15:0] == SIG_OEM)
            begin
                cmd_mode_r <= 1'b1;
                sig_oem_r  <= 1'b1;
            end
        end
    end

    // pin drive: oe low means driving; before command mode the buffer stays on
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            line_o      <= 1'b1;
            line_oe_n_o <= 1'b0;
        end
        else if (!cmd_mode_r)
        begin
            line_o      <= 1'b1; // [R15] [R16] master overdrives
            line_oe_n_o <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_TKO:
                begin
                    line_o      <= 1'b0; // [R8] [R11]
                    line_oe_n_o <= 1'b0;
                end
                ST_SEND:
                begin
                    line_o      <= (tx_cnt_r < (tx_word_r[15] ? CNT_W'(BIT_ONE_CYC)
                                                             : CNT_W'(BIT_ZERO_CYC)));
                    line_oe_n_o <= 1'b0;
                end
                ST_REL:
                begin
                    // zero handover bit, then low until release at three quarters
                    line_o      <= (tx_cnt_r < CNT_W'(BIT_ZERO_CYC)); // [R9] [R11]
                    line_oe_n_o <= 1'b0;
                end
                default:
                begin
                    line_o      <= 1'b1;
                    line_oe_n_o <= 1'b1; // [R15]
                end
            endcase
        end
    end

    // checksum engine: one word per valid, msb first, last word low byte zero
    always_comb
    begin
        logic [15:0] w;
        logic [8:0]  c;
        w = crc_in_i.last ? (crc_in_i.word & CRC_LOW_MASK) : crc_in_i.word; // [R20]
        c = {1'b0, crc_r};
        for (int i = 15; i >= 0; i--)
        begin
            c = {c[7:0], w[i]}; // [R19]
            if (c[8])
                c = c ^ CRC_POLY; // [R21]
        end
        crc_nxt = c[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            crc_r      <= CRC_SEED; // [R21]
            crc_o      <= '0;
            crc_done_o <= 1'b0;
            chk_err_r  <= 1'b0;
        end
        else
        begin
            crc_done_o <= 1'b0;
            if (crc_in_i.valid)
            begin
                crc_r <= crc_in_i.last ? CRC_SEED : crc_nxt;
                if (crc_in_i.last)
                begin
                    crc_o      <= crc_nxt;
                    crc_done_o <= 1'b1;
                    if (crc_nxt != crc_in_i.word[7:0])
                        chk_err_r <= 1'b1; // [R18] sticky until reset
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cmd_mode_o    <= 1'b0;
            sig_tier1_o   <= 1'b0;
            ctrl_status_o <= '0;
        end
        else
        begin
            cmd_mode_o    <= cmd_mode_r;
            sig_tier1_o   <= sig_tier1_r; // [R22] broader rights flag
            ctrl_status_o <= '0;
            ctrl_status_o[CHK_ERR_BIT] <= chk_err_r; // [R18]
            ctrl_status_o[SIG_A_BIT]   <= sig_oem_r;
            ctrl_status_o[SIG_B_BIT]   <= sig_tier1_r;
        end
    end
endmodule

// [verif/owps_checker.sv]
// port relations of the one-wire programming slave
// assumes one clock domain; bound onto owps_slave below
`timescale 1ns/1ps
module owps_checker
    import owps_pkg::*;
(
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   line_o,
    input wire logic                   line_oe_n_o,
    input wire logic                   wr_valid_o,
    input wire logic                   cmd_mode_o,
    input wire logic                   sig_tier1_o,
    input wire logic [15:0]            ctrl_status_o,
    input wire owps_pkg::owps_crc_in_t crc_in_i,
    input wire logic                   crc_done_o
);
    import owps_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_wr_in_cmd:
    assert property (wr_valid_o |-> cmd_mode_o) else $error("write strobe outside command mode");
    a_wr_single_pulse:
    assert property (wr_valid_o |=> !wr_valid_o) else $error("write strobe too long");
    a_cmd_mode_sticky:
    assert property (cmd_mode_o |=> cmd_mode_o) else $error("command mode dropped");
    a_entry_high:
    assert property (!cmd_mode_o |-> line_o) else $error("pin not high outside command mode");
    a_tier1_flag:
    assert property (sig_tier1_o |-> cmd_mode_o && ctrl_status_o[SIG_B_BIT])
        else $error("tier flag without status");
    a_takeover_low:
    assert property ($fell(line_oe_n_o) && cmd_mode_o |-> (!line_oe_n_o && !line_o) [*8])
        else $error("takeover not driven low");
    a_crc_done:
    assert property (crc_in_i.valid && crc_in_i.last |=> crc_done_o) else $error("no crc done");
    a_done_cause:
    assert property (crc_done_o |-> $past(crc_in_i.valid && crc_in_i.last))
        else $error("crc done without last word");
    a_chk_err_sticky:
    assert property (ctrl_status_o[CHK_ERR_BIT] |=> ctrl_status_o[CHK_ERR_BIT])
        else $error("checksum error flag lost");
    c_entry: cover property ($rose(cmd_mode_o));
    c_write: cover property (wr_valid_o);
    c_takeover: cover property ($fell(line_oe_n_o));
    c_crc: cover property (crc_done_o);
endmodule

bind owps_slave owps_checker chk (.clk_i, .sys_rst_i, .line_o, .line_oe_n_o, .wr_valid_o,
    .cmd_mode_o, .sig_tier1_o, .ctrl_status_o, .crc_in_i, .crc_done_o);

// [verif/owps_master.sv]
// programming master model on the far side of the shared pin
// assumes line_i is the resolved pin level with a pull-up
`timescale 1ns/1ps
module owps_master
    import owps_pkg::*;
#(
    parameter int MAS_TKO_CYC = 100
)
(
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o,
    output logic      drive_n_o
);
    initial
    begin
        line_o = 1'b1;
        drive_n_o = 1'b1;
    end
    task automatic hold(input logic v, input int n);
        line_o = v;
        repeat (n) @(negedge clk_i);
    endtask
    task automatic send_bit(input logic b);
        hold(1'b1, b ? BIT_ONE_CYC : BIT_ZERO_CYC);
        hold(1'b0, BIT_PERIOD_CYC - (b ? BIT_ONE_CYC : BIT_ZERO_CYC));
    endtask
    // n below 24 leaves the frame unfinished on purpose
    task automatic frame(input logic [23:0] bits, input int n);
        drive_n_o = 1'b0;
        hold(1'b0, BIT_PERIOD_CYC);
        for (int i = 23; i > 23 - n; i--)
            send_bit(bits[i]);
    endtask
    task automatic stop();
        hold(1'b1, BIT_PERIOD_CYC);
        drive_n_o = 1'b1;
    endtask
    task automatic write(input logic [6:0] a, input logic [15:0] d);
        frame({a, 1'b0, d}, 24);
        stop();
    endtask
    task automatic read(input logic [6:0] a, output logic [15:0] d);
        int w;
        frame({a, 1'b1, 16'h0000}, 8);
        hold(1'b1, BIT_ZERO_CYC);
        hold(1'b0, RELEASE_CYC - BIT_ZERO_CYC);
        drive_n_o = 1'b1;
        // 16 data bits, then the device handover bit
        for (int i = 16; i >= 0; i--)
        begin
            w = 0;
            for (int t = 0; t < 1000 && line_i !== 1'b1; t++)
                @(negedge clk_i);
            for (; w < 1000 && line_i === 1'b1; w++)
                @(negedge clk_i);
            if (i > 0)
                d[i-1] = (w >= BIT_THRESH_CYC);
        end
        drive_n_o = 1'b0; // overlaps the device low drive
        hold(1'b0, MAS_TKO_CYC);
        stop();
    endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the one-wire programming slave
// assumes the master model on the far side and a pull-up on the pin
`timescale 1ns/1ps
module tb;
    import owps_pkg::*;
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic         diag_mode_i = 1'b0;
    logic [15:0]  rd_data_i = 16'hA5C3;
    owps_crc_in_t crc_in_i = '0;
    logic         line, dut_line, dut_oe_n, m_line, m_drive_n;
    logic         rd_req_o, wr_valid_o, cmd_mode_o, sig_tier1_o, crc_done_o;
    owps_wr_t     wr_o;
    logic [15:0]  ctrl_status_o, rdv;
    logic [7:0]   crc_o, crc_last;
    int           failures = 0;
    int           n_tests = 0;
    int           n_wr = 0;
    int           n_rd = 0;
    int           n_crc = 0;
    int           c;
    localparam int PROG_GAP_CYC = 400; // cell programming time, plain default
    owps_wr_t     rows [3] = '{'{7'h00, 16'h8001}, '{7'h7F, 16'hFFFF}, '{7'h2A, 16'h5AA5}};
    logic [15:0]  words [12] = '{16'h0000, 16'h0100, 16'h1300, 16'h1000, 16'h1FFE, 16'hFFFF,
                                 16'h1200, 16'h0000, 16'h0099, 16'h0F89, 16'h80FA, 16'h00BE};
    always #2.5 clk_i = ~clk_i;
    // any driver pulls low; released pin floats up on the pull-up
    assign line = (m_drive_n ? 1'b1 : m_line) & (dut_oe_n ? 1'b1 : dut_line);
    owps_slave dut (.clk_i, .sys_rst_i, .line_i(line), .line_o(dut_line), .line_oe_n_o(dut_oe_n),
        .diag_mode_i, .area_match_i(1'b0), .rd_data_i, .rd_req_o, .wr_o, .wr_valid_o,
        .cmd_mode_o, .sig_tier1_o, .ctrl_status_o, .crc_in_i, .crc_o, .crc_done_o);
    owps_master m (.clk_i, .line_i(line), .line_o(m_line), .drive_n_o(m_drive_n));
    always @(posedge clk_i)
    begin
        n_wr += (wr_valid_o === 1'b1);
        n_rd += (rd_req_o === 1'b1);
        if (crc_done_o === 1'b1)
        begin
            n_crc++;
            crc_last = crc_o;
        end
    end
    task automatic report(input bit ok, input string s);
        n_tests++;
        if (!ok)
        begin
            failures++;
            $display("unexpected at %0t: %s", $time, s);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string s);
        report(got === exp, s);
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string s);
        report(got === exp, s);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic crc_run(input logic [7:0] low);
        int c0;
        c0 = n_crc;
        for (int i = 0; i < 12; i++)
        begin
            crc_in_i = '{1'b1, i == 11, (i == 11) ? {words[i][15:8], low} : words[i]};
            @(negedge clk_i);
        end
        crc_in_i = '0;
        for (int t = 0; t < 10 && n_crc == c0; t++)
            @(negedge clk_i);
        cmp_word(n_crc - c0, 1, "checksum done");
        cmp_word(32'(crc_last), 32'h0000_00B3, "checksum value");
    endtask
    task automatic entry(input logic [15:0] sig, input logic exp_mode, input logic [15:0] st);
        m.write(ADDR_SIGNATURE, sig);
        cmp_bit(cmd_mode_o, exp_mode, "command mode");
        cmp_word(32'(ctrl_status_o), 32'(st), "status word");
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_i);
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end
    initial
    begin
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        cmp_bit(dut_line, 1'b1, "idle pin level");
        cmp_bit(dut_oe_n, 1'b0, "idle pin drive");
        m.write(7'h10, 16'h1234);
        cmp_word(n_wr, 0, "write outside command mode");
        entry(SIG_TIER1, 1'b1, 16'h0002);
        cmp_bit(sig_tier1_o, 1'b1, "tier signature");
        cmp_bit(dut_oe_n, 1'b1, "pin released");
        $display("test entry done");
        foreach (rows[i])
        begin
            c = n_wr;
            m.write(rows[i].addr, rows[i].data);
            cmp_word(n_wr - c, 1, "write strobes");
            cmp_word(32'(wr_o), 32'(rows[i]), "write contents");
            repeat (PROG_GAP_CYC) @(negedge clk_i);
        end
        $display("test writes done");
        m.read(7'h03, rdv);
        cmp_word(32'(rdv), 32'h0000_A5C3, "read word");
        cmp_word(n_rd, 1, "read requests");
        cmp_bit(dut_oe_n, 1'b1, "released after read");
        $display("test read done");
        c = n_wr;
        m.frame({7'h11, 1'b0, 16'hFFFF}, 12); // write cut short
        m.hold(1'b0, TIMEOUT_CYC + 100);
        m.stop();
        repeat (TIMEOUT_CYC + 100) @(negedge clk_i);
        m.write(7'h22, 16'h0F0F);
        cmp_word(n_wr - c, 1, "writes after abort");
        cmp_word(32'(wr_o), 32'({7'h22, 16'h0F0F}), "write after abort");
        $display("test timeout done");
        crc_run(8'hB3);
        cmp_bit(ctrl_status_o[CHK_ERR_BIT], 1'b0, "no checksum error");
        crc_run(8'hBE);
        cmp_bit(ctrl_status_o[CHK_ERR_BIT], 1'b1, "checksum error");
        $display("test checksum done");
        sys_rst_i = 1'b1;
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        cmp_bit(cmd_mode_o, 1'b0, "mode after reset");
        repeat (ENTRY_WIN_CYC + 100) @(negedge clk_i);
        entry(SIG_OEM, 1'b0, 16'h0000);
        diag_mode_i = 1'b1;
        entry(SIG_OEM, 1'b1, 16'h0004);
        cmp_bit(sig_tier1_o, 1'b0, "oem signature");
        $display("test late entry done");
        test_done();
    end
endmodule
